// ---- shared/fpr_pkg.sv ----
// Shared constants and types for the power-mode and recovery link.
package fpr_pkg;
  // System clock and link timing.
  localparam int unsigned SYS_CLK_PERIOD_NS    = 10;
  localparam int unsigned MIN_DESELECT_TIME_NS = 50;
  localparam int unsigned DESELECT_CYC         =
    (MIN_DESELECT_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int unsigned SCLK_HALF_CYC        = 8;
  localparam logic [3:0]  HALF_LOAD            = 4'(SCLK_HALF_CYC - 1);
  localparam logic [3:0]  GAP_LOAD             = 4'(DESELECT_CYC - 1);

  // Frame clock counts; index 0 is the first burst of step one.
  localparam int unsigned BURST_NUM  = 6;
  localparam logic [5:0]  CNT_MAX    = 6'h3f;
  localparam logic [BURST_NUM-1:0][5:0] BURST_LEN =
    {6'h21, 6'h19, 6'h11, 6'h0d, 6'h09, 6'h07};
  localparam logic [5:0]  PLR_LEN    = 6'h08;
  localparam logic [5:0]  RESCUE_LEN = 6'h10;
  localparam logic [5:0]  CMD_LEN    = 6'h08;
  localparam logic [2:0]  SEQ_IDLE   = 3'h0;
  localparam logic [2:0]  SEQ_STEP2  = 3'h6;
  localparam logic [2:0]  FRAME_LAST = 3'h6;

  // Command codes; the values are arbitrary.
  localparam logic [7:0]  CMD_ENTER_DPD   = 8'h5a;
  localparam logic [7:0]  CMD_RELEASE_DPD = 8'ha5;

  typedef enum logic [2:0] {
    PM_STANDBY = 3'b001,
    PM_ACTIVE  = 3'b010,
    PM_DEEP    = 3'b100
  } fpr_pmode_t;

  typedef enum logic [1:0] {
    PROTO_EXT  = 2'h0,
    PROTO_DUAL = 2'h1,
    PROTO_QUAD = 2'h2,
    PROTO_RSVD = 2'h3
  } fpr_proto_t;

  typedef enum logic [1:0] {
    HC_ENTER_DPD   = 2'h0,
    HC_RELEASE_DPD = 2'h1,
    HC_PLR         = 2'h2,
    HC_RESCUE      = 2'h3
  } fpr_hcmd_t;
endpackage

// ---- shared/fpr_link_if.sv ----
// Serial link between the flash controller end and the flash device end.
`timescale 1ns/1ns
interface fpr_link_if;
  logic cs_n;
  logic sclk;
  logic dq_data;
  logic dq_hold;
  modport host (output cs_n, output sclk, output dq_data, output dq_hold);
  modport dev  (input cs_n, input sclk, input dq_data, input dq_hold);
endinterface

// ---- core/fpr_sync.sv ----
// Two-flop synchroniser into the system clock domain.
`timescale 1ns/1ns
module fpr_sync #(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ---- core/fpr_dev.sv ----
// Device end: power-mode tracking and recovery sequence detection.
// Operation
// - Chip select low means selected and active.
// - After deselect, stay active until idle, then standby.
// - Enter-deep-power-down command moves device to deep state.
// - Release command returns device to normal operation.
// - Power loss may leave odd protocol, in-place mode.
// - Power loss recovery forces extended SPI until power-up.
// - Interface rescue restores configuration-defined interface state.
// - Rescue resets interface only; internal operations continue.
// - Host keeps step order and minimum deselect time.
// - Step one is six all-ones framed bursts.
// - Power loss step two is eight all-ones clocks.
// - Power loss recovery leaves dual/quad for extended SPI.
// - Rescue step two is sixteen all-ones clocks.
// - In double rate, host holds ones both edges.
// - Rescue leaves dual/quad, accepts extended SPI commands.
// - Host should rewrite configuration after either sequence.
// - Step one sets in-place confirmation bit, ending it.
`timescale 1ns/1ns
module fpr_dev (
  input  wire logic                 sys_clk_in,
  input  wire logic                 reset_in,
  fpr_link_if.dev                   link,
  input  wire logic                 busy_in,
  input  wire fpr_pkg::fpr_proto_t  nvcr_proto_in,
  input  wire logic                 nvcr_execute_in_place_in,
  output fpr_pkg::fpr_pmode_t       power_mode_out,
  output fpr_pkg::fpr_proto_t       protocol_out,
  output logic                      execute_in_place_out,
  output logic                      plr_lock_out,
  output logic                      iface_reload_out
);
  import fpr_pkg::*;

  // Link clock domain. The serial clock stops between frames, so this side
  // only gathers the frame; judging happens in the system domain.
  logic       frame_clr;
  logic       in_frame_q;
  logic       first_edge;
  logic       line_ones;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic       ones_q;
  logic       ones_d;
  logic [7:0] byte_q;
  logic [7:0] byte_d;
  logic       tog_q;
  logic       tog_d;

  // Deselect ends the frame by itself, without needing another link edge.
  assign frame_clr  = reset_in | link.cs_n;
  assign first_edge = ~in_frame_q;
  assign line_ones  = link.dq_data & link.dq_hold;
  assign cnt_d      = first_edge ? 6'h01 :
                      (cnt_q == CNT_MAX) ? cnt_q : cnt_q + 6'h01;
  assign ones_d     = first_edge ? line_ones : (ones_q & line_ones);
  assign byte_d     = {byte_q[6:0], link.dq_data};
  assign tog_d      = tog_q ^ first_edge;

  always_ff @(posedge link.sclk or posedge frame_clr) begin
    if (frame_clr) begin
      in_frame_q <= 1'b0;
    end else begin
      in_frame_q <= 1'b1;
    end
  end

  always_ff @(posedge link.sclk or posedge reset_in) begin
    if (reset_in) begin
      cnt_q  <= 6'h00;
      ones_q <= 1'b0;
      byte_q <= 8'h00;
      tog_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      ones_q <= ones_d;
      byte_q <= byte_d;
      tog_q  <= tog_d;
    end
  end

  // System clock domain.
  logic [1:0] sync_s;
  logic       cs_s;
  logic       tog_s;
  logic       cs_prev_q;
  logic       tog_seen_q;
  logic       cs_rise;
  logic       new_frame;
  logic [5:0] frame_len;
  logic       frame_ones;

  fpr_sync #(
    .WIDTH   (2),
    .RST_VAL (2'b01)
  ) u_sync (
    .clk_in   (sys_clk_in),
    .reset_in (reset_in),
    .async_in ({tog_q, link.cs_n}),
    .sync_out (sync_s)
  );

  assign cs_s      = sync_s[0];
  assign tog_s     = sync_s[1];
  assign cs_rise   = cs_s & ~cs_prev_q;
  // The frame words are frozen while the link clock stands, and only read
  // after the synchronised deselect, so they are stable when sampled.
  assign new_frame = tog_s ^ tog_seen_q;
  assign frame_len  = new_frame ? cnt_q : 6'h00;
  assign frame_ones = new_frame & ones_q;

  // Sequence detection.
  logic [2:0] seq_q;
  logic [2:0] seq_d;
  logic [5:0] burst_exp;
  logic       burst_hit;
  logic       first_hit;
  logic       plr_hit;
  logic       rescue_hit;
  logic       step1_done;
  logic       enter_cmd;
  logic       release_cmd;

  assign burst_exp  = (seq_q < SEQ_STEP2) ? BURST_LEN[seq_q] : 6'h00;
  assign burst_hit  = cs_rise & frame_ones & (frame_len == burst_exp);
  assign first_hit  = cs_rise & frame_ones & (frame_len == BURST_LEN[0]);
  assign plr_hit    = cs_rise & frame_ones & (seq_q == SEQ_STEP2) &
                      (frame_len == PLR_LEN);
  assign rescue_hit = cs_rise & frame_ones & (seq_q == SEQ_STEP2) &
                      (frame_len == RESCUE_LEN);
  assign step1_done = burst_hit & (seq_q == SEQ_STEP2 - 3'h1);
  assign enter_cmd   = cs_rise & new_frame & (frame_len == CMD_LEN) &
                       (byte_q == CMD_ENTER_DPD);
  assign release_cmd = cs_rise & new_frame & (frame_len == CMD_LEN) &
                       (byte_q == CMD_RELEASE_DPD);

  // Any frame that breaks the pattern restarts the search, so a stray
  // first burst still counts as the start of a new attempt.
  always_comb begin
    seq_d = seq_q;
    if (cs_rise) begin
      if (burst_hit) begin
        seq_d = seq_q + 3'h1;
      end else if (first_hit) begin
        seq_d = 3'h1;
      end else begin
        seq_d = SEQ_IDLE;
      end
    end
  end

  // Power mode.
  fpr_pmode_t pm_q;
  fpr_pmode_t pm_d;

  always_comb begin
    unique case (pm_q)
      PM_DEEP: begin
        pm_d = release_cmd ? PM_ACTIVE : PM_DEEP;
      end
      PM_ACTIVE: begin
        if (enter_cmd) begin
          pm_d = PM_DEEP;
        end else if (cs_s && !busy_in) begin
          pm_d = PM_STANDBY;
        end else begin
          pm_d = PM_ACTIVE;
        end
      end
      PM_STANDBY: begin
        pm_d = cs_s ? PM_STANDBY : PM_ACTIVE;
      end
      default: begin
        pm_d = PM_STANDBY;
      end
    endcase
  end

  // Interface state. The first cycle after reset release catches the
  // stored configuration, which may be a damaged one.
  logic       boot_q;
  fpr_proto_t proto_d;
  logic       inpl_d;
  logic       lock_d;

  always_comb begin
    proto_d = protocol_out;
    inpl_d  = execute_in_place_out;
    lock_d  = plr_lock_out;
    if (!boot_q) begin
      proto_d = nvcr_proto_in;
      inpl_d  = nvcr_execute_in_place_in;
      lock_d  = 1'b0;
    end else if (plr_hit) begin
      proto_d = PROTO_EXT;
      inpl_d  = 1'b0;
      lock_d  = 1'b1;
    end else if (rescue_hit) begin
      proto_d = PROTO_EXT;
      inpl_d  = nvcr_execute_in_place_in & ~plr_lock_out;
    end else if (step1_done) begin
      inpl_d  = 1'b0;
    end
  end

  // Busy is only read by the power-mode logic; rescue touches no state
  // that internal operations depend on.
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cs_prev_q        <= 1'b1;
      tog_seen_q       <= 1'b0;
      seq_q            <= SEQ_IDLE;
      pm_q             <= PM_STANDBY;
      boot_q           <= 1'b0;
      protocol_out     <= PROTO_EXT;
      execute_in_place_out <= 1'b0;
      plr_lock_out     <= 1'b0;
      iface_reload_out <= 1'b0;
    end else begin
      cs_prev_q        <= cs_s;
      tog_seen_q       <= cs_rise ? tog_s : tog_seen_q;
      seq_q            <= seq_d;
      pm_q             <= pm_d;
      boot_q           <= 1'b1;
      protocol_out     <= proto_d;
      execute_in_place_out <= inpl_d;
      plr_lock_out     <= lock_d;
      iface_reload_out <= rescue_hit & boot_q;
    end
  end

  assign power_mode_out = pm_q;
endmodule

// ---- core/fpr_host.sv ----
// Host end: issues power commands and the two recovery sequences.
`timescale 1ns/1ns
module fpr_host (
  input  wire logic                sys_clk_in,
  input  wire logic                reset_in,
  fpr_link_if.host                 link,
  input  wire logic                cmd_valid_in,
  input  wire fpr_pkg::fpr_hcmd_t  cmd_in,
  output logic                     cmd_ready_out,
  output logic                     done_out
);
  import fpr_pkg::*;

  typedef enum logic [5:0] {
    HS_IDLE  = 6'b000001,
    HS_SETUP = 6'b000010,
    HS_HIGH  = 6'b000100,
    HS_LOW   = 6'b001000,
    HS_HOLD  = 6'b010000,
    HS_GAP   = 6'b100000
  } fpr_hstate_t;

  fpr_hstate_t st_q;
  fpr_hstate_t st_d;
  fpr_hcmd_t   op_q;
  fpr_hcmd_t   op_d;
  logic [2:0]  frm_q;
  logic [2:0]  frm_d;
  logic [5:0]  bit_q;
  logic [5:0]  bit_d;
  logic [3:0]  tmr_q;
  logic [3:0]  tmr_d;
  logic [7:0]  sh_q;
  logic [7:0]  sh_d;
  logic        cs_n_d;
  logic        sclk_d;
  logic        data_d;
  logic        ready_d;
  logic        done_d;

  logic        is_rec;
  logic        last_frame;
  logic [5:0]  frame_len;
  logic [5:0]  step2_len;
  logic        tmr_zero;
  logic [7:0]  new_code;

  assign is_rec     = op_q[1];
  assign last_frame = ~is_rec | (frm_q == FRAME_LAST);
  assign step2_len  = (op_q == HC_PLR) ? PLR_LEN : RESCUE_LEN;
  assign frame_len  = !is_rec ? CMD_LEN :
                      (frm_q < FRAME_LAST) ? BURST_LEN[frm_q] : step2_len;
  assign tmr_zero   = (tmr_q == 4'h0);
  assign new_code   = (cmd_in == HC_ENTER_DPD) ? CMD_ENTER_DPD :
                      (cmd_in == HC_RELEASE_DPD) ? CMD_RELEASE_DPD :
                      8'hff;

  // The serial clock is divided down from the system clock; data moves on
  // the falling edge so it is steady at each rising edge and through the high phase after it.
  always_comb begin
    st_d    = st_q;
    op_d    = op_q;
    frm_d   = frm_q;
    bit_d   = bit_q;
    tmr_d   = tmr_zero ? tmr_q : tmr_q - 4'h1;
    sh_d    = sh_q;
    cs_n_d  = link.cs_n;
    sclk_d  = link.sclk;
    data_d  = link.dq_data;
    ready_d = 1'b0;
    done_d  = 1'b0;
    unique case (st_q)
      HS_IDLE: begin
        ready_d = 1'b1;
        if (cmd_valid_in) begin
          ready_d = 1'b0;
          op_d    = cmd_in;
          frm_d   = 3'h0;
          bit_d   = 6'h00;
          sh_d    = new_code;
          data_d  = new_code[7];
          cs_n_d  = 1'b0;
          tmr_d   = HALF_LOAD;
          st_d    = HS_SETUP;
        end
      end
      HS_SETUP, HS_LOW: begin
        if (tmr_zero) begin
          sclk_d = 1'b1;
          bit_d  = bit_q + 6'h01;
          tmr_d  = HALF_LOAD;
          st_d   = HS_HIGH;
        end
      end
      HS_HIGH: begin
        if (tmr_zero) begin
          sclk_d = 1'b0;
          tmr_d  = HALF_LOAD;
          if (bit_q == frame_len) begin
            st_d = HS_HOLD;
          end else begin
            sh_d   = {sh_q[6:0], 1'b1};
            data_d = sh_q[6];
            st_d   = HS_LOW;
          end
        end
      end
      HS_HOLD: begin
        if (tmr_zero) begin
          cs_n_d = 1'b1;
          tmr_d  = GAP_LOAD;
          st_d   = HS_GAP;
        end
      end
      HS_GAP: begin
        if (tmr_zero) begin
          if (last_frame) begin
            done_d  = 1'b1;
            ready_d = 1'b1;
            st_d    = HS_IDLE;
          end else begin
            frm_d  = frm_q + 3'h1;
            bit_d  = 6'h00;
            sh_d   = 8'hff;
            data_d = 1'b1;
            cs_n_d = 1'b0;
            tmr_d  = HALF_LOAD;
            st_d   = HS_SETUP;
          end
        end
      end
      default: begin
        st_d = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      st_q          <= HS_IDLE;
      op_q          <= HC_ENTER_DPD;
      frm_q         <= 3'h0;
      bit_q         <= 6'h00;
      tmr_q         <= 4'h0;
      sh_q          <= 8'hff;
      link.cs_n     <= 1'b1;
      link.sclk     <= 1'b0;
      link.dq_data  <= 1'b1;
      link.dq_hold  <= 1'b1;
      cmd_ready_out <= 1'b0;
      done_out      <= 1'b0;
    end else begin
      st_q          <= st_d;
      op_q          <= op_d;
      frm_q         <= frm_d;
      bit_q         <= bit_d;
      tmr_q         <= tmr_d;
      sh_q          <= sh_d;
      link.cs_n     <= cs_n_d;
      link.sclk     <= sclk_d;
      link.dq_data  <= data_d;
      link.dq_hold  <= 1'b1;
      cmd_ready_out <= ready_d;
      done_out      <= done_d;
    end
  end
endmodule

// ---- bench/fpr_link_props.sv ----
// Concurrent checks on the host-to-device link and the device outputs.
`timescale 1ns/1ns
module fpr_link_props
  import fpr_pkg::*;
(
  input wire logic               sys_clk_in,
  input wire logic               reset_in,
  input wire logic               cs_n,
  input wire logic               sclk,
  input wire logic               dq_hold,
  input wire logic               busy_in,
  input wire fpr_pkg::fpr_pmode_t power_mode_out,
  input wire fpr_pkg::fpr_proto_t protocol_out,
  input wire logic               execute_in_place_out,
  input wire logic               plr_lock_out,
  input wire logic               iface_reload_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // Five low cycles leave room for the synchroniser lag on chip select.
  a_sel_is_active: assert property (
    (!cs_n)[*5] ##0 (power_mode_out != PM_DEEP) |-> power_mode_out == PM_ACTIVE)
    else $error("selected device not active");
  a_busy_keeps_active: assert property (
    cs_n && busy_in && power_mode_out == PM_ACTIVE |=> power_mode_out != PM_STANDBY)
    else $error("standby while busy");
  a_idle_to_standby: assert property (
    (cs_n && !busy_in)[*8] |-> power_mode_out != PM_ACTIVE)
    else $error("idle device still active");
  a_deep_holds: assert property (
    power_mode_out == PM_DEEP && !cs_n |=> power_mode_out == PM_DEEP)
    else $error("deep state left inside a frame");
  a_reload_pulse: assert property (iface_reload_out |=> !iface_reload_out)
    else $error("reload pulse too long");
  a_reload_ext: assert property (
    iface_reload_out |-> ##[0:1] protocol_out == PROTO_EXT)
    else $error("rescue left protocol not extended");
  a_reload_deselect: assert property (
    iface_reload_out |-> $past(cs_n, 1) && $past(cs_n, 2) && $past(cs_n, 3))
    else $error("reload not judged at deselect");
  a_lock_sticks: assert property (plr_lock_out |=> plr_lock_out)
    else $error("recovery lock dropped");
  a_lock_ext: assert property (
    plr_lock_out && $past(plr_lock_out) |-> protocol_out == PROTO_EXT && !execute_in_place_out)
    else $error("locked device not in plain extended mode");
  a_gap_min: assert property ($rose(cs_n) |-> cs_n[*5])
    else $error("deselect gap too short");
  a_sclk_idle: assert property (cs_n |-> !sclk)
    else $error("serial clock runs while deselected");
  a_hold_high: assert property (!cs_n |-> dq_hold)
    else $error("hold line low in a frame");
endmodule

// ---- bench/flash_power_mode_interface_rescue_tb.sv ----
// Self-checking bench: host and device ends joined, plus a device fed by a bench driver.
`timescale 1ns/1ns
module flash_power_mode_interface_rescue_tb;
  import fpr_pkg::*;
  logic       sys_clk_in, reset_in, busy_in, nvcr_execute_in_place_in, cmd_valid_in;
  logic       execute_in_place_out, plr_lock_out, iface_reload_out, cmd_ready_out, done_out;
  logic       inpl_2, lock_2, reload_2;
  fpr_proto_t nvcr_proto_in, protocol_out, proto_2, exp_proto;
  fpr_pmode_t power_mode_out, mode_2, exp_mode;
  fpr_hcmd_t  cmd_in;
  logic       exp_inpl, exp_lock;
  int         error_cnt = 0, tests_run = 0, reload_cnt = 0, reload_cnt2 = 0, exp_reload;
  int         seed = 32'h2f53889b;
  fpr_link_if link ();
  fpr_link_if link_2 ();
  fpr_host i_fpr_host (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .link(link),
    .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
    .done_out(done_out));
  fpr_dev i_fpr_dev (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .link(link),
    .busy_in(busy_in), .nvcr_proto_in(nvcr_proto_in),
    .nvcr_execute_in_place_in(nvcr_execute_in_place_in),
    .power_mode_out(power_mode_out), .protocol_out(protocol_out),
    .execute_in_place_out(execute_in_place_out), .plr_lock_out(plr_lock_out),
    .iface_reload_out(iface_reload_out));
  fpr_dev i_fpr_dev_2 (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .link(link_2),
    .busy_in(busy_in), .nvcr_proto_in(nvcr_proto_in),
    .nvcr_execute_in_place_in(nvcr_execute_in_place_in),
    .power_mode_out(mode_2), .protocol_out(proto_2), .execute_in_place_out(inpl_2),
    .plr_lock_out(lock_2), .iface_reload_out(reload_2));
  fpr_link_props i_fpr_link_props (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
    .cs_n(link.cs_n), .sclk(link.sclk), .dq_hold(link.dq_hold), .busy_in(busy_in),
    .power_mode_out(power_mode_out), .protocol_out(protocol_out),
    .execute_in_place_out(execute_in_place_out), .plr_lock_out(plr_lock_out),
    .iface_reload_out(iface_reload_out));

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      reload_cnt = 0;
      reload_cnt2 = 0;
    end else begin
      reload_cnt += iface_reload_out;
      reload_cnt2 += reload_2;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    tests_run++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic do_reset();
    reset_in <= 1'b1;
    repeat (20) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    exp_mode = PM_STANDBY;
    exp_proto = nvcr_proto_in;
    exp_inpl = nvcr_execute_in_place_in;
    exp_lock = 1'b0;
    exp_reload = 0;
    check(protocol_out, exp_proto);
    check(execute_in_place_out, exp_inpl);
    check(power_mode_out, exp_mode);
    check(plr_lock_out, exp_lock);
  endtask

  // The model settles after the gap; outputs lag chip select by three cycles.
  task automatic issue(input fpr_hcmd_t c);
    int n;
    for (n = 0; n < 200 && cmd_ready_out !== 1'b1; n++) @(posedge sys_clk_in);
    check(cmd_ready_out, 1'b1);
    cmd_valid_in <= 1'b1;
    cmd_in <= c;
    @(posedge sys_clk_in);
    cmd_valid_in <= 1'b0;
    for (n = 0; n < 5000 && done_out !== 1'b1; n++) @(posedge sys_clk_in);
    // A missing done pulse counts as a mismatch here, so a hang cannot pass.
    check(done_out, 1'b1);
    check(cmd_ready_out, 1'b1);
    repeat (10) @(posedge sys_clk_in);
    case (c)
      HC_ENTER_DPD: exp_mode = PM_DEEP;
      HC_RELEASE_DPD: exp_mode = PM_STANDBY;
      HC_PLR: begin
        exp_lock = 1'b1;
        exp_proto = PROTO_EXT;
        exp_inpl = 1'b0;
      end
      default: begin
        exp_reload++;
        exp_proto = PROTO_EXT;
        exp_inpl = nvcr_execute_in_place_in & ~exp_lock;
      end
    endcase
    if (exp_mode != PM_DEEP) exp_mode = busy_in ? PM_ACTIVE : PM_STANDBY;
    check(power_mode_out, exp_mode);
    check(protocol_out, exp_proto);
    check(execute_in_place_out, exp_inpl);
    check(plr_lock_out, exp_lock);
    check(8'(reload_cnt), 8'(exp_reload));
  endtask

  // Bench-made link clock for the second device; dq_data flips when released, dq_hold stays high.
  task automatic frame2(input int n);
    link_2.dq_data = 1'b1;
    link_2.cs_n = 1'b0;
    #80;
    repeat (n) begin
      link_2.sclk = 1'b1;
      #80;
      link_2.sclk = 1'b0;
      #80;
    end
    link_2.cs_n = 1'b1;
    link_2.dq_data = 1'b0;
    #200;
  endtask

  task automatic seq2(input int bad, input int last);
    for (int i = 0; i < BURST_NUM; i++) frame2(int'(BURST_LEN[i]) - int'(i == bad));
    frame2(last);
    #400;
  endtask

  initial begin
    fpr_hcmd_t c;
    reset_in = 1'b1;
    busy_in = 1'b0;
    cmd_valid_in = 1'b0;
    cmd_in = HC_ENTER_DPD;
    nvcr_proto_in = PROTO_QUAD;
    nvcr_execute_in_place_in = 1'b1;
    link_2.cs_n = 1'b1;
    link_2.sclk = 1'b0;
    link_2.dq_data = 1'b0;
    link_2.dq_hold = 1'b1;
    @(posedge sys_clk_in);
    do_reset();
    issue(HC_ENTER_DPD);
    issue(HC_ENTER_DPD);
    issue(HC_RELEASE_DPD);
    busy_in <= 1'b1;
    issue(HC_RESCUE);
    busy_in <= 1'b0;
    repeat (10) @(posedge sys_clk_in);
    check(power_mode_out, PM_STANDBY);
    issue(HC_PLR);
    issue(HC_RESCUE);
    for (int k = 0; k < 8; k++) begin
      c = fpr_hcmd_t'(2'($random(seed)));
      if (exp_mode == PM_DEEP && c[1]) issue(HC_RELEASE_DPD);
      issue(c);
    end
    // The host rewrites the stored configuration after the recovery runs.
    nvcr_proto_in <= fpr_proto_t'(2'($random(seed)));
    nvcr_execute_in_place_in <= 1'($random(seed));
    do_reset();
    issue(HC_RESCUE);
    #3;
    seq2(9, 16);
    check(8'(reload_cnt2), 8'h01);
    check(inpl_2, nvcr_execute_in_place_in);
    check(proto_2, PROTO_EXT);
    frame2(16);
    #400;
    check(8'(reload_cnt2), 8'h01);
    seq2(3, 16);
    check(8'(reload_cnt2), 8'h01);
    seq2(9, 8);
    check(lock_2, 1'b1);
    check(proto_2, PROTO_EXT);
    check(inpl_2, 1'b0);
    check(mode_2, PM_STANDBY);
    conclude();
  end

  initial begin
    #950000;
    error_cnt++;
    conclude();
  end
endmodule
